/* File: scp_pkg.sv */
// Shared constants and types of the serial configuration port slave.
// Assumes one serial frame layout: 16-bit instruction, then data bytes.
package scp_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Frame layout
   localparam int SCP_INSTR_BITS = 16;
   localparam int SCP_BYTE_BITS = 8;
   localparam int SCP_ADDR_BITS = 13;
   localparam int SCP_RW_POS = 15;
   localparam int SCP_LEN_HI = 14;
   localparam int SCP_LEN_LO = 13;
   localparam logic [3:0] SCP_INSTR_LAST_CNT = 4'hF;
   localparam logic [2:0] SCP_BYTE_LAST_CNT = 3'h7;
   localparam logic [1:0] SCP_LEN_STREAM = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // Register space
   localparam logic [12:0] SCP_ADDR_PORTCFG = 13'h0000;
   localparam logic [12:0] SCP_ADDR_RBSRC = 13'h0004;
   localparam logic [12:0] SCP_ADDR_LAST = 13'h0232;
   localparam int SCP_REG_COUNT = 32'h233;
   localparam logic [7:0] SCP_PORTCFG_RST = 8'h18;
   localparam logic [7:0] SCP_REG_RST = 8'h00;

   // Field positions, each port bit has a mirrored twin
   localparam int SCP_SDO_ACTIVE_BIT = 0;
   localparam int SCP_SDO_ACTIVE_MIR = 7;
   localparam int SCP_LSB_FIRST_BIT = 1;
   localparam int SCP_LSB_FIRST_MIR = 6;
   localparam int SCP_RBSRC_BIT = 0;
   localparam int SCP_UPDATE_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Link-side and core-side state
   typedef enum logic [1:0] {
      SCP_PH_INSTR = 2'b00,
      SCP_PH_DATA = 2'b01,
      SCP_PH_DONE = 2'b10
   } scp_phase_t;

   typedef struct packed {
      scp_phase_t phase;
      logic [3:0] cnt;
      logic [15:0] sr;
      logic rw;
      logic [1:0] len;
      logic [1:0] left;
      logic [12:0] addr;
      logic [7:0] tx;
      logic cfg_lsb;
      logic cfg_sdo;
      logic upd_tgl;
   } scp_link_t;

   typedef struct packed {
      logic upd_prev;
      logic upd_pulse;
   } scp_core_t;

endpackage

/* File: scp_sync.sv */
// Two-stage level synchroniser into the core clock domain.
// Assumes each bit is a quasi-static level or a toggle, never a pulse.
`timescale 1ns/1ps
module scp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Levels
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end

endmodule

/* File: scp_slave.sv */
// Serial configuration port slave: instruction decode, shadow and active
// register banks, readback driver, and status crossing into the core clock.
// Assumes the host drives sclk_i only while select is low.
//
// Operation
// - Write bits sampled on serial clock rise, read bits launched on fall.
// - Port bit 0 selects shared pin (0, reset) or separate readback pin.
// - Select high keeps both data outputs released.
// - First sixteen rising edges after select falls carry the instruction.
// - Instruction: read flag on top, two length bits, thirteen address bits.
// - Length code 00,01,10 gives one to three bytes; 11 streams.
// - Counted transfers pause on byte boundaries and resume on select low; a resumed read leaves its first bit undriven.
// - Select rising mid-byte discards the partial data and restarts.
// - Streaming runs up to the byte at 0x232, stepping the address each byte.
// - Streaming visits every address, reserved and blank ones included.
// - Writes go to the shadow bank; self-clearing update copies all.
// - Reads shift out N bytes, or stream until select rises or the byte at 0x232 is sent.
// - Readback on shared pin when bidirectional, separate pin otherwise.
// - Readback source bit picks shadow or active bank.
// - Register space is addresses 0x000 to 0x232 only.
// - Most-significant-first transfers decrement the address per byte.
// - Bit order bits act at once, without an update.
// - Least-significant-first transfers increment the address per byte.
// - Streaming stops at 0x232; decrement wraps 0x000 to 0x232 first.
`timescale 1ns/1ps
module scp_slave (
   // Core clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // Serial link
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe_n_o,
   output logic serial_readback_out_o,
   output logic serial_readback_out_oe_n_o,
   // Core-side status
   output logic update_pulse_o,
   output logic select_idle_o,
   output logic lsb_first_o,
   output logic sdo_mode_o
);
   import scp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain storage
   scp_link_t q;
   scp_link_t n;
   logic cs_hi;
   logic [7:0] shd [SCP_REG_COUNT];
   logic [7:0] act [SCP_REG_COUNT];
   logic wr_en;
   logic upd;
   logic [7:0] wr_byte;
   logic [9:0] wr_idx;
   logic [15:0] sh;
   logic restart;
   logic rb_active;
   logic out_bit;

   // Shift one bit in, direction set by the bit order
   function automatic logic [15:0] shift_in(input logic [15:0] sr, input logic b,
                                           input logic lsb);
      shift_in = lsb ? {b, sr[15:1]} : {sr[14:0], b};
   endfunction

   // Completed data byte inside the shifter
   function automatic logic [7:0] data_byte(input logic [15:0] sr, input logic lsb);
      data_byte = lsb ? sr[15:8] : sr[7:0];
   endfunction

   // Address in the implemented range
   function automatic logic in_range(input logic [12:0] a);
      in_range = (a <= SCP_ADDR_LAST);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Select-seen flag: set while select is high, so the next rising edge
   // knows whether the frame paused cleanly or was cut mid-byte
   always_ff @(posedge sclk_i or posedge cs_n_i or posedge rst_i) begin
      if (rst_i || cs_n_i) begin
         cs_hi <= 1'b1;
      end else begin
         cs_hi <= 1'b0;
      end
   end

   assign rb_active = shd[SCP_ADDR_RBSRC[9:0]][SCP_RBSRC_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Link next-state logic
   always_comb begin
      logic [7:0] db;
      logic load;
      db = 8'h00;
      load = 1'b0;
      n = q;
      wr_en = 1'b0;
      upd = 1'b0;
      wr_byte = 8'h00;
      wr_idx = q.addr[9:0];
      sh = shift_in(q.sr, sdio_i, q.cfg_lsb);
      // Cut mid-byte, finished cycle or ended stream: this bit opens an instruction
      restart = cs_hi && ((q.cnt[2:0] != 3'h0) || (q.phase == SCP_PH_DONE) ||
                ((q.phase == SCP_PH_DATA) && (q.len == SCP_LEN_STREAM)));
      n.sr = sh;
      if (restart) begin
         n.phase = SCP_PH_INSTR;
         n.cnt = 4'h1;
      end else begin
         unique case (q.phase)
            SCP_PH_INSTR: begin
               n.cnt = q.cnt + 4'h1;
               if (q.cnt == SCP_INSTR_LAST_CNT) begin
                  // Decode after the sixteenth bit
                  n.cnt = 4'h0;
                  n.phase = SCP_PH_DATA;
                  n.rw = sh[SCP_RW_POS];
                  n.len = sh[SCP_LEN_HI:SCP_LEN_LO];
                  n.left = sh[SCP_LEN_HI:SCP_LEN_LO];
                  n.addr = sh[12:0];
                  load = 1'b1;
               end
            end
            SCP_PH_DATA: begin
               n.cnt = {1'b0, q.cnt[2:0] + 3'h1};
               if (q.cnt[2:0] == SCP_BYTE_LAST_CNT) begin
                  n.cnt = 4'h0;
                  db = data_byte(sh, q.cfg_lsb);
                  if (!q.rw && in_range(q.addr)) begin
                     // Writes land in the shadow bank; the update write to 0x232 also lands in the active bank
                     wr_en = 1'b1;
                     wr_byte = db;
                     if (q.addr == SCP_ADDR_LAST) begin
                        wr_byte[SCP_UPDATE_BIT] = 1'b0;
                        upd = db[SCP_UPDATE_BIT];
                        n.upd_tgl = q.upd_tgl ^ db[SCP_UPDATE_BIT];
                     end
                     if (q.addr == SCP_ADDR_PORTCFG) begin
                        // Port settings act immediately, no update needed
                        n.cfg_lsb = db[SCP_LSB_FIRST_BIT] | db[SCP_LSB_FIRST_MIR];
                        n.cfg_sdo = db[SCP_SDO_ACTIVE_BIT] | db[SCP_SDO_ACTIVE_MIR];
                     end
                  end
                  // Address generator
                  if (q.cfg_lsb) begin
                     n.addr = q.addr + 13'h0001;
                  end else if (q.addr == 13'h0000) begin
                     n.addr = SCP_ADDR_LAST;
                  end else begin
                     n.addr = q.addr - 13'h0001;
                  end
                  if (q.len == SCP_LEN_STREAM) begin
                     if (q.addr == SCP_ADDR_LAST) begin
                        n.phase = SCP_PH_DONE;
                     end
                  end else if (q.left == 2'h0) begin
                     n.phase = SCP_PH_DONE;
                  end else begin
                     n.left = q.left - 2'h1;
                  end
                  load = 1'b1;
               end
            end
            SCP_PH_DONE: begin
               // Extra clocks after the last byte are ignored
               n.cnt = 4'h0;
            end
            default: begin
               n.phase = SCP_PH_INSTR;
               n.cnt = 4'h0;
            end
         endcase
      end
      // Readback byte for the next data slot, from the chosen bank
      if (load) begin
         if (!in_range(n.addr)) begin
            n.tx = 8'h00;
         end else if (rb_active) begin
            n.tx = act[n.addr[9:0]];
         end else begin
            n.tx = shd[n.addr[9:0]];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link state register, sampled on the rising serial clock
   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{phase: SCP_PH_INSTR, cnt: 4'h0, sr: 16'h0000, rw: 1'b0, len: 2'h0,
                left: 2'h0, addr: 13'h0000, tx: 8'h00, cfg_lsb: 1'b0, cfg_sdo: 1'b0,
                upd_tgl: 1'b0};
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register banks; the whole active bank loads on one edge so that
   // dependent settings never see a half-applied change
   always_ff @(posedge sclk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < SCP_REG_COUNT; i++) begin
            shd[i] <= (i == 0) ? SCP_PORTCFG_RST : SCP_REG_RST;
            act[i] <= (i == 0) ? SCP_PORTCFG_RST : SCP_REG_RST;
         end
      end else begin
         if (wr_en) begin
            shd[wr_idx] <= wr_byte;
         end
         if (upd) begin
            for (int i = 0; i < SCP_REG_COUNT; i++) begin
               act[i] <= (10'(i) == wr_idx) ? wr_byte : shd[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Readback launch on the falling serial clock; select high forces the
   // enables off without needing a clock edge
   assign out_bit = q.cfg_lsb ? q.tx[q.cnt[2:0]] : q.tx[3'h7 - q.cnt[2:0]];

   always_ff @(negedge sclk_i or posedge cs_n_i or posedge rst_i) begin
      if (rst_i || cs_n_i) begin
         sdio_oe_n_o <= 1'b1;
         serial_readback_out_oe_n_o <= 1'b1;
         sdio_o <= 1'b0;
         serial_readback_out_o <= 1'b0;
      end else begin
         sdio_o <= out_bit;
         serial_readback_out_o <= out_bit;
         sdio_oe_n_o <= !((q.phase == SCP_PH_DATA) && q.rw && !q.cfg_sdo);
         serial_readback_out_oe_n_o <= !((q.phase == SCP_PH_DATA) && q.rw && q.cfg_sdo);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Crossing into the core clock: update as a toggle, the rest as levels
   logic [3:0] sync_q;
   scp_core_t c;
   scp_core_t next_c;

   scp_sync #(.W(4), .RST_VAL(4'h2)) u_sync (
      .clk_i(ref_clk_i),
      .rst_i(rst_i),
      .d_i({q.cfg_sdo, q.cfg_lsb, cs_n_i, q.upd_tgl}),
      .q_o(sync_q)
   );

   // Edge detect reads only the second stage
   always_comb begin
      next_c.upd_prev = sync_q[0];
      next_c.upd_pulse = sync_q[0] ^ c.upd_prev;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         c <= '{upd_prev: 1'b0, upd_pulse: 1'b0};
      end else begin
         c <= next_c;
      end
   end

   assign update_pulse_o = c.upd_pulse;
   assign select_idle_o = sync_q[1];
   assign lsb_first_o = sync_q[2];
   assign sdo_mode_o = sync_q[3];

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the link domain
   logic eob;
   assign eob = (q.phase == SCP_PH_DATA) && (q.cnt[2:0] == SCP_BYTE_LAST_CNT) && !cs_hi;

   AST_INSTR_DONE: assert property (@(posedge sclk_i) disable iff (rst_i)
      (q.phase == SCP_PH_INSTR) && (q.cnt == SCP_INSTR_LAST_CNT) && !cs_hi
      |=> (q.phase == SCP_PH_DATA) && (q.cnt == 4'h0))
      else $error("instruction phase did not end after sixteen bits");

   AST_ABORT_MIDBYTE: assert property (@(posedge sclk_i) disable iff (rst_i)
      cs_hi && (q.cnt[2:0] != 3'h0)
      |=> (q.phase == SCP_PH_INSTR) && (q.cnt == 4'h1))
      else $error("mid-byte select rise did not restart the port");

   AST_DEC_STEP: assert property (@(posedge sclk_i) disable iff (rst_i)
      eob && !q.cfg_lsb && (q.addr != 13'h0000) |=> q.addr == $past(q.addr) - 13'h0001)
      else $error("address did not decrement");

   AST_INC_STEP: assert property (@(posedge sclk_i) disable iff (rst_i)
      eob && q.cfg_lsb |=> q.addr == $past(q.addr) + 13'h0001)
      else $error("address did not increment");

   AST_DEC_WRAP: assert property (@(posedge sclk_i) disable iff (rst_i)
      eob && !q.cfg_lsb && (q.addr == 13'h0000) |=> q.addr == SCP_ADDR_LAST)
      else $error("decrement did not wrap to the last address");

   AST_STREAM_STOP: assert property (@(posedge sclk_i) disable iff (rst_i)
      eob && (q.len == SCP_LEN_STREAM) && (q.addr == SCP_ADDR_LAST)
      |=> (q.phase == SCP_PH_DONE) ##1 ($past(cs_hi) || (q.phase == SCP_PH_DONE)))
      else $error("stream did not stop at the last address");

   AST_UPDATE_COPY: assert property (@(posedge sclk_i) disable iff (rst_i)
      upd |=> (act[SCP_ADDR_RBSRC[9:0]] == $past(shd[SCP_ADDR_RBSRC[9:0]])) &&
              (act[SCP_ADDR_LAST[9:0]][SCP_UPDATE_BIT] == 1'b0))
      else $error("update did not copy the shadow bank");

   AST_SHADOW_ONLY: assert property (@(posedge sclk_i) disable iff (rst_i)
      wr_en && !upd && (wr_idx == SCP_ADDR_RBSRC[9:0])
      |=> act[SCP_ADDR_RBSRC[9:0]] == $past(act[SCP_ADDR_RBSRC[9:0]]))
      else $error("a plain write reached the active bank");

   AST_WRITE_NO_DRIVE: assert property (@(posedge sclk_i) disable iff (rst_i)
      (q.phase != SCP_PH_DATA) || !q.rw |-> ##0 sdio_oe_n_o && serial_readback_out_oe_n_o)
      else $error("data pin driven outside a read data phase");

   AST_PIN_SELECT: assert property (@(posedge sclk_i) disable iff (rst_i)
      q.cfg_sdo ? sdio_oe_n_o : serial_readback_out_oe_n_o)
      else $error("readback on the wrong pin");

   AST_SELECT_RELEASE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cs_n_i && $past(cs_n_i) |-> sdio_oe_n_o && serial_readback_out_oe_n_o)
      else $error("pins driven while select is high");

   COV_READ: cover property (@(posedge sclk_i) disable iff (rst_i)
      eob && q.rw);
   COV_STREAM_END: cover property (@(posedge sclk_i) disable iff (rst_i)
      eob && (q.len == SCP_LEN_STREAM) && (q.addr == SCP_ADDR_LAST));
   COV_UPDATE: cover property (@(posedge sclk_i) disable iff (rst_i) upd);
   COV_RESUME: cover property (@(posedge sclk_i) disable iff (rst_i)
      cs_hi && !restart && (q.phase == SCP_PH_DATA));

endmodule

/* File: scp_host_model.sv */
// Behavioural host that masters the serial link of the port slave.
// Assumes the bench resolves the shared pin and feeds the read level.
`timescale 1ns/1ps
module scp_host_model (
   // Read level seen by the host
   input wire logic rd_i,
   // Link outputs
   output logic sclk_o,
   output logic cs_n_o,
   output logic hbit_o,
   output logic drv_o
);
   logic [7:0] wd [4];
   logic [7:0] rd [4];

   ////////////////////////////////////////////////////////////////////////////////
   // Idle levels: the link clock stands low outside frames
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      hbit_o = 1'b0;
      drv_o = 1'b0;
   end

   // One frame; stall raises select after that bit count, cut aborts there
   task automatic xfer(input logic [15:0] ins, input int n, input logic lsb,
                       input int stall, input int cut);
      int nb;
      int k;
      nb = (cut > 0) ? cut : 16 + 8 * n;
      cs_n_o = 1'b0;
      #10;
      for (int i = 0; i < nb; i++) begin
         // Whole fields reverse in time when least significant goes first
         k = lsb ? (i < 16 ? i : (i - 16) % 8) : (i < 16 ? 15 - i : 7 - (i - 16) % 8);
         drv_o = (i < 16) || !ins[15];
         hbit_o = (i < 16) ? ins[k] : wd[(i - 16) / 8][k];
         #16 sclk_o = 1'b1;
         if (i >= 16) begin
            rd[(i - 16) / 8][k] = rd_i;
         end
         #16 sclk_o = 1'b0;
         // Stalls only ever land on byte boundaries
         if (i + 1 == stall) begin
            cs_n_o = 1'b1;
            #100 cs_n_o = 1'b0;
            #10;
         end
      end
      drv_o = 1'b0;
      #10 cs_n_o = 1'b1;
      #50;
   endtask
endmodule

/* File: serial_control_port_slave_tb.sv */
// Self-checking bench for the serial configuration port slave.
// Assumes the host model owns link timing; the bench owns reset and checks.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module serial_control_port_slave_tb;
   logic ref_clk_i, rst_i, lsb, uni, flip, pin_bad, busy_seen;
   logic sclk, cs_n, hbit, drv, sdio_o, sdio_oe_n, rb_o, rb_oe_n;
   logic upd_p, idle, lsb_o, mode_o;
   int fails, checks_done, upd_cnt;
   // Released lines show a changing pattern, never the last value
   wire sdio_w = !sdio_oe_n ? sdio_o : drv ? hbit : flip;
   wire rb_w = !rb_oe_n ? rb_o : flip;
   wire rd_w = uni ? rb_w : sdio_w;

   scp_slave u_scp_slave (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk),
      .cs_n_i(cs_n), .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n),
      .serial_readback_out_o(rb_o), .serial_readback_out_oe_n_o(rb_oe_n),
      .update_pulse_o(upd_p), .select_idle_o(idle), .lsb_first_o(lsb_o),
      .sdo_mode_o(mode_o));
   scp_host_model u_scp_host_model (.rd_i(rd_w), .sclk_o(sclk), .cs_n_o(cs_n),
      .hbit_o(hbit), .drv_o(drv));

   ////////////////////////////////////////////////////////////////////////////////
   // Core clock, filler pattern and update pulse counter
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      flip <= ~flip;
      if (upd_p === 1'b1) begin
         upd_cnt <= upd_cnt + 1;
      end
      // A stuck idle status would otherwise pass the single reset check
      if (idle === 1'b0) begin
         busy_seen <= 1'b1;
      end
   end
   // Pins must be released after select rises and never fight the host
   always @(posedge cs_n) begin
      #2 if (sdio_oe_n !== 1'b1 || rb_oe_n !== 1'b1) pin_bad = 1'b1;
   end
   always @(posedge sclk) begin
      if (sdio_oe_n !== 1'b1 && (drv || uni)) pin_bad = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Access tasks
   task automatic wr(input logic [1:0] len, input logic [12:0] a, input int n,
                     input int stall, input int cut, input logic [31:0] d);
      for (int i = 0; i < 4; i++) begin
         u_scp_host_model.wd[i] = d[31 - 8 * i -: 8];
      end
      u_scp_host_model.xfer({1'b0, len, 3'h0, a[9:0]}, n, lsb, stall, cut);
   endtask

   task automatic rdchk(input logic [1:0] len, input logic [12:0] a, input int n,
                        input logic [23:0] e);
      u_scp_host_model.xfer({1'b1, len, 3'h0, a[9:0]}, n, lsb, 0, 0);
      for (int i = 0; i < n; i++) begin
         `CHK("read byte", e[23 - 8 * i -: 8], u_scp_host_model.rd[i])
      end
   endtask

   task automatic end_sim();
      `CHK("pin release", 1'b0, pin_bad)
      `CHK("busy seen", 1'b1, busy_seen)
      if (fails == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Watchdog against a hung run
   initial begin
      #1000000;
      fails++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {lsb, uni, flip, pin_bad, busy_seen} = 5'h00;
      {fails, checks_done, upd_cnt} = '0;
      rst_i = 1'b1;
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      `CHK("idle", 1'b1, idle)
      `CHK("mode", 1'b0, mode_o)
      `CHK("order", 1'b0, lsb_o)
      `CHK("oe", 2'h3, {sdio_oe_n, rb_oe_n})
      rdchk(2'h0, 13'h0000, 1, 24'h180000);
      // Three bytes with a stall after the first data byte
      wr(2'h2, 13'h0012, 3, 24, 0, 32'hA1B2C300);
      rdchk(2'h2, 13'h0012, 3, 24'hA1B2C3);
      // Mid-byte abort, then a fresh frame must decode cleanly
      wr(2'h0, 13'h0020, 1, 0, 20, 32'h5A000000);
      wr(2'h0, 13'h0021, 1, 0, 12, 32'h77000000);
      wr(2'h0, 13'h0021, 1, 0, 0, 32'h66000000);
      rdchk(2'h1, 13'h0021, 2, 24'h660000);
      // Stall after one byte, then a three-clock burst abandons the rest
      wr(2'h1, 13'h0022, 2, 24, 27, 32'h3C4D0000);
      rdchk(2'h1, 13'h0022, 2, 24'h3C6600);
      // Beyond the last implemented address reads come back empty
      rdchk(2'h0, 13'h0233, 1, 24'h000000);
      // Streaming writes step down and stop after the top address
      wr(2'h3, 13'h0016, 4, 0, 0, 32'h11223344);
      rdchk(2'h0, 13'h0013, 1, 24'h440000);
      wr(2'h3, 13'h0001, 4, 0, 0, 32'h00180077);
      rdchk(2'h0, 13'h0231, 1, 24'h000000);
      rdchk(2'h3, 13'h0001, 3, 24'h001800);
      // Active bank stays empty until the update
      wr(2'h0, 13'h0004, 1, 0, 0, 32'h01000000);
      rdchk(2'h0, 13'h0012, 1, 24'h000000);
      wr(2'h0, 13'h0232, 1, 0, 0, 32'h01000000);
      repeat (10) @(posedge ref_clk_i);
      `CHK("update count", 1, upd_cnt)
      rdchk(2'h1, 13'h0012, 2, 24'hA1B200);
      rdchk(2'h0, 13'h0232, 1, 24'h000000);
      // Separate readback pin
      wr(2'h0, 13'h0000, 1, 0, 0, 32'h99000000);
      repeat (10) @(posedge ref_clk_i);
      `CHK("mode", 1'b1, mode_o)
      uni = 1'b1;
      rdchk(2'h0, 13'h0012, 1, 24'hA10000);
      // Least significant first acts at once and steps the address up
      wr(2'h0, 13'h0000, 1, 0, 0, 32'hDB000000);
      repeat (10) @(posedge ref_clk_i);
      `CHK("order", 1'b1, lsb_o)
      lsb = 1'b1;
      wr(2'h1, 13'h0030, 2, 0, 0, 32'hC4D50000);
      wr(2'h0, 13'h0232, 1, 0, 0, 32'h01000000);
      repeat (10) @(posedge ref_clk_i);
      `CHK("update count", 2, upd_cnt)
      rdchk(2'h1, 13'h0030, 2, 24'hC4D500);
      rdchk(2'h0, 13'h0031, 1, 24'hD50000);
      end_sim();
   end
endmodule
